// ---- hdl/pds_consts.svh ----
// Register map, field positions, reset values and timing figures of the
// pre-driver protection and serial register block. No processes here.
//
// Operation
// RULE1 - After switching starts, wait the selected blanking time before sampling drain-source.
// RULE2 - Short detected: set high or low short flag, summary flag, pull alarm low.
// RULE3 - Restart mode 0: shorted channel off, re-enabled after about one millisecond.
// RULE4 - Restart mode 1: shorted channel stays off until its short flag cleared.
// RULE5 - Host disables all outputs, then sets one load probe enable bit.
// RULE6 - Output sense bit reads 1 while output lies between 0.5V and 1.5V.
// RULE7 - Supply below warning threshold sets warning flag and pulls alarm low.
// RULE8 - Supply lockout disables everything and resets logic until supply recovers; code resets logic, but drive.hsOn and drive.lsOn follow pins.
// RULE9 - A supply lockout is recorded in a readable status flag.
// RULE10 - Gate supply low sets its flag in second status register, alarm low.
// RULE11 - Bootstrap low sets channel flag, pulls alarm low, starts refresh cycle.
// RULE12 - Overtemperature: set flags, alarm, stay off until cool and flag cleared.
// RULE13 - Overtemperature warning follows temperature and never drives the alarm.
// RULE14 - Frame is 16 bits: 3 address, direction (1 write), 12 data.
// RULE15 - Serial input sampled on serial clock rising edges while select low.
// RULE16 - Serial output driven only while chip select is low.
// RULE17 - Leading address bits select both read source and write target.
// RULE18 - Effective enable and input are pin XOR software bit.
// RULE19 - Short detection runs only while channel's bit 11 enable is set.
// RULE20 - Status bit 0 is the OR of all other fault flags.
// RULE21 - Writing 1 clears a status fault flag; alarm holds until cleared.
// RULE22 - Writing 1 toggles reverse pump enable; writing 0 does nothing.
// RULE23 - High-side over-threshold flags short to ground; low-side, short to supply.
// RULE24 - Writing 1 clears bootstrap-low flags; writing 0 has no effect.
// RULE25 - Writes commit only at select rise ending a complete 16-bit frame.
// RULE26 - Read frames shift the addressed 12-bit register out in data positions.
`ifndef PDS_CONSTS_SVH
`define PDS_CONSTS_SVH

// Clock and time figures
`define PDS_CLK_NS        4
`define PDS_CYC(ns)       (((ns) + `PDS_CLK_NS - 1) / `PDS_CLK_NS)
`define PDS_BLANK0_NS     1000
`define PDS_BLANK1_NS     2000
`define PDS_BLANK2_NS     5000
`define PDS_BLANK3_NS     10000
`define PDS_BLANK4_NS     25000
`define PDS_BLANK5_NS     100000
`define PDS_BLANK6_NS     500000
`define PDS_BLANK7_NS     1000000
`define PDS_RETRY_NS      1000000

// Register addresses
`define PDS_ADDR_OUT      3'h0
`define PDS_ADDR_CHANA    3'h1
`define PDS_ADDR_CHANC    3'h3
`define PDS_ADDR_MODE     3'h4
`define PDS_ADDR_ALARM    3'h5
`define PDS_ADDR_SUPPLY   3'h6

// Reset values
`define PDS_RST_OUT       12'h000
`define PDS_RST_CHAN      12'h01c
`define PDS_RST_MODE      12'h000

// Field positions
`define PDS_F_SCEN        11
`define PDS_F_BT          5
`define PDS_F_DT          2
`define PDS_F_SR          0
`define PDS_F_GN          8
`define PDS_F_OLS         6
`define PDS_F_OVERCURRENT_RESTART_MODE        2
`define PDS_F_MUX         0
`define PDS_F_SC          3
`define PDS_F_PUMP        11
`define PDS_F_DIR         12
`define PDS_F_ADDR        13
`define PDS_FRAME_BITS    5'h10
`define PDS_HDR_BITS      5'h03
`define PDS_LAST_BIT      5'h0f

`endif

// ---- hdl/pds_pkg.sv ----
// Types shared by the pre-driver protection and serial register block.
// Constants live in pds_consts.svh; this package holds only types.
package pds_pkg;

    // Serial slave phases
    typedef enum logic [1:0] {PS_IDLE, PS_SHIFT, PS_OVER} pds_spi_e;

    // Pins and comparator outputs, all asynchronous to clk_sys
    typedef struct packed {
        logic       chipSelectN;
        logic       serialClk;
        logic       serialIn;
        logic [2:0] channelEnablePin;
        logic [2:0] channelInputPin;
        logic [2:0] hsDsOver;
        logic [2:0] lsDsOver;
        logic [2:0] outputSense;
        logic       overtempShutdown;
        logic       overtempWarning;
        logic       supplyLowWarning;
        logic       supplyLockout;
        logic       gateSupplyLow;
        logic [2:0] bootSupplyLow;
    } pds_pins_s;

    // Drive decisions per channel, index 0 is channel A
    typedef struct packed {
        logic [2:0] enable;
        logic [2:0] level;
        logic [2:0] hsOn;
        logic [2:0] lsOn;
        logic [2:0] loadProbe;
    } pds_drive_s;

    // Settings handed to the analog sections
    typedef struct packed {
        logic [2:0][2:0] deadTimeSel;
        logic [2:0][1:0] slewSel;
        logic [2:0][2:0] senseGainSel;
        logic [2:0][2:0] shortThresholdSel;
        logic [1:0]      senseChannelSel;
        logic            reversePumpOn;
    } pds_analog_s;

    // Whole state of the block
    typedef struct packed {
        pds_pins_s       s1;
        pds_pins_s       s2;
        logic [11:0]     outCtl;
        logic [2:0][11:0] chanCfg;
        logic [11:0]     modeCfg;
        logic [2:0]      schFlag;
        logic [2:0]      sclFlag;
        logic            otsFlag;
        logic            uvwFlag;
        logic            uvloFlag;
        logic            vguvFlag;
        logic [2:0]      bsuvFlag;
        logic            pumpOn;
        logic [2:0][17:0] blankCnt;
        logic [2:0][17:0] retryCnt;
        logic [2:0]      chanOff;
        logic [2:0]      prevHs;
        logic [2:0]      prevLs;
        logic [2:0]      bsuvPrev;
        logic            refresh;
        pds_spi_e        spi;
        logic [4:0]      bitCnt;
        logic [15:0]     inShift;
        logic [11:0]     rdWord;
        logic            outBit;
        logic            sclkPrev;
        logic            csPrev;
    } pds_state_s;

endpackage : pds_pkg

// ---- hdl/pds_regs.sv ----
// Protection, diagnostic and serial register logic of a three-channel
// half-bridge pre-driver. Assumes analog comparators and pins arrive
// asynchronously on pinsIn and that an outside pad resolves the open-drain
// alarm and the serial output from their enables.
`timescale 1ns/1ps
`include "pds_consts.svh"

module pds_regs
    import pds_pkg::*;
#(
    parameter int BLANK4_CYC = `PDS_CYC(`PDS_BLANK4_NS),
    parameter int BLANK5_CYC = `PDS_CYC(`PDS_BLANK5_NS),
    parameter int BLANK6_CYC = `PDS_CYC(`PDS_BLANK6_NS),
    parameter int BLANK7_CYC = `PDS_CYC(`PDS_BLANK7_NS),
    parameter int RETRY_CYC  = `PDS_CYC(`PDS_RETRY_NS)
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Pins and comparators
    input  wire pds_pins_s   pinsIn,
    // Serial output pin
    output logic             serialOut,
    output logic             serialOutEn,
    // Open-drain alarm pin
    output logic             alarmOutN,
    output logic             alarmOutNEn,
    // Drive and analog settings
    output pds_drive_s       drive,
    output pds_analog_s      analog,
    output logic             bootRefreshStart
);

    // Counters are 18 bits wide; larger figures cannot be served
    initial begin
        if (BLANK7_CYC < 1 || BLANK7_CYC > 262143 || RETRY_CYC < 1 || RETRY_CYC > 262143 ||
            BLANK4_CYC < 1 || BLANK5_CYC < 1 || BLANK6_CYC < 1)
            $error("pds_regs: cycle counts out of range");
    end

    // Blanking selector to cycle count
    function automatic logic [17:0] blankLimit(input logic [2:0] sel);
        case (sel)
            3'h0:    blankLimit = 18'(`PDS_CYC(`PDS_BLANK0_NS));
            3'h1:    blankLimit = 18'(`PDS_CYC(`PDS_BLANK1_NS));
            3'h2:    blankLimit = 18'(`PDS_CYC(`PDS_BLANK2_NS));
            3'h3:    blankLimit = 18'(`PDS_CYC(`PDS_BLANK3_NS));
            3'h4:    blankLimit = 18'(BLANK4_CYC);
            3'h5:    blankLimit = 18'(BLANK5_CYC);
            3'h6:    blankLimit = 18'(BLANK6_CYC);
            default: blankLimit = 18'(BLANK7_CYC);
        endcase
    endfunction : blankLimit

    // Reset image of the state
    function automatic pds_state_s rstState();
        pds_state_s r;
        r = '0;
        r.s1.chipSelectN = 1'b1;
        r.s2.chipSelectN = 1'b1;
        r.csPrev = 1'b1;
        r.outCtl = `PDS_RST_OUT;
        r.chanCfg = {3{`PDS_RST_CHAN}};
        r.modeCfg = `PDS_RST_MODE;
        r.spi = PS_IDLE;
        return r;
    endfunction : rstState

    localparam pds_state_s RST = rstState();

    pds_state_s st_r;
    pds_state_s st_nxt;

    // Combinational views of the state
    logic [2:0]  effEn;
    logic [2:0]  effIn;
    logic [2:0]  hsOn;
    logic [2:0]  lsOn;
    logic        summary;
    logic        alarmCause;
    logic [11:0] alarmWord;
    logic [11:0] rdMux;
    logic        commit;
    logic [2:0]  wrAddr;
    logic [11:0] wrData;

    // Channel drive from pins and software bits
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            effEn[c] = st_r.s2.channelEnablePin[c] ^ st_r.outCtl[2*c];   // RULE18
            effIn[c] = st_r.s2.channelInputPin[c] ^ st_r.outCtl[2*c+1]; // RULE18
        end
        hsOn = effEn & effIn & ~st_r.chanOff & {3{~st_r.otsFlag}};   // RULE12
        lsOn = effEn & ~effIn & ~st_r.chanOff & {3{~st_r.otsFlag}};
    end

    // Summary and alarm; warning-over-temperature takes no part
    assign summary    = |{st_r.uvloFlag, st_r.uvwFlag, st_r.schFlag, st_r.sclFlag,
                          st_r.otsFlag}; // RULE20
    assign alarmCause = summary | st_r.vguvFlag | (|st_r.bsuvFlag); // RULE13
    assign alarmWord  = {st_r.pumpOn, st_r.s2.overtempWarning, st_r.uvloFlag, st_r.uvwFlag,
                         st_r.schFlag, st_r.sclFlag, st_r.otsFlag, summary};

    // Read source picked by the address bits, sampled on the fourth serial clock rising edge
    always_comb begin
        case (st_r.inShift[2:0]) // RULE17
            `PDS_ADDR_OUT:    rdMux = {st_r.s2.outputSense, st_r.outCtl[8:0]}; // RULE6
            `PDS_ADDR_MODE:   rdMux = st_r.modeCfg;
            `PDS_ADDR_ALARM:  rdMux = alarmWord;
            `PDS_ADDR_SUPPLY: rdMux = {8'h00, st_r.bsuvFlag[0], st_r.bsuvFlag[1],
                                       st_r.bsuvFlag[2], st_r.vguvFlag};
            3'h7:             rdMux = 12'h000;
            default:          rdMux = st_r.chanCfg[2'(st_r.inShift[2:0] - `PDS_ADDR_CHANA)];
        endcase
    end

    // Complete write frame ends on the select rising edge
    assign commit = st_r.s2.chipSelectN & ~st_r.csPrev && st_r.spi == PS_OVER
                    && st_r.inShift[`PDS_F_DIR]; // RULE25 RULE14
    assign wrAddr = st_r.inShift[15:`PDS_F_ADDR];
    assign wrData = st_r.inShift[11:0];

    // Next state
    always_comb begin
        logic [2:0]  schSet;
        logic [2:0]  sclSet;
        logic [11:0] clrA;
        logic [3:0]  clrS;
        logic [17:0] lim;
        st_nxt = st_r;
        schSet = '0;
        sclSet = '0;
        clrA   = '0;
        clrS   = '0;
        lim    = '0;
        st_nxt.s1 = pinsIn;
        st_nxt.s2 = st_r.s1;
        st_nxt.sclkPrev = st_r.s2.serialClk;
        st_nxt.csPrev   = st_r.s2.chipSelectN;
        st_nxt.prevHs   = hsOn;
        st_nxt.prevLs   = lsOn;
        st_nxt.bsuvPrev = st_r.s2.bootSupplyLow;
        st_nxt.refresh  = |(st_r.s2.bootSupplyLow & ~st_r.bsuvPrev); // RULE11

        // Blanking, sampling and short response per channel
        for (int c = 0; c < 3; c++) begin
            lim = blankLimit(st_r.chanCfg[c][`PDS_F_BT +: 3]);
            if (hsOn[c] != st_r.prevHs[c] || lsOn[c] != st_r.prevLs[c])
                st_nxt.blankCnt[c] = '0; // RULE1
            else if ((hsOn[c] | lsOn[c]) && st_r.blankCnt[c] < lim)
                st_nxt.blankCnt[c] = st_r.blankCnt[c] + 18'h0_0001;
            if (st_r.blankCnt[c] >= lim && st_r.chanCfg[c][`PDS_F_SCEN]) begin // RULE19
                schSet[c] = hsOn[c] & st_r.s2.hsDsOver[c]; // RULE23
                sclSet[c] = lsOn[c] & st_r.s2.lsDsOver[c]; // RULE23
            end
            if (schSet[c] | sclSet[c]) begin
                st_nxt.chanOff[c]  = 1'b1;
                st_nxt.retryCnt[c] = '0;
            end else if (st_r.chanOff[c]) begin
                if (st_r.modeCfg[`PDS_F_OVERCURRENT_RESTART_MODE])
                    st_nxt.chanOff[c] = st_r.schFlag[c] | st_r.sclFlag[c]; // RULE4
                else if (st_r.retryCnt[c] >= 18'(RETRY_CYC - 1))
                    st_nxt.chanOff[c] = 1'b0; // RULE3
                else
                    st_nxt.retryCnt[c] = st_r.retryCnt[c] + 18'h0_0001;
            end
        end

        // Register writes
        if (commit) begin
            case (wrAddr)
                `PDS_ADDR_OUT:    st_nxt.outCtl = {3'h0, wrData[8:0]};
                `PDS_ADDR_MODE:   st_nxt.modeCfg = wrData;
                `PDS_ADDR_ALARM: begin
                    clrA = wrData; // RULE21
                    st_nxt.pumpOn = st_r.pumpOn ^ wrData[`PDS_F_PUMP]; // RULE22
                end
                `PDS_ADDR_SUPPLY: clrS = {wrData[0], wrData[1], wrData[2], wrData[3]}; // RULE24
                3'h7:             st_nxt.outCtl = st_r.outCtl;
                default:          st_nxt.chanCfg[2'(wrAddr - `PDS_ADDR_CHANA)] = wrData;
            endcase
        end

        // Flags: a set in the clearing cycle wins
        st_nxt.schFlag  = (st_r.schFlag & ~clrA[7:5]) | schSet; // RULE2
        st_nxt.sclFlag  = (st_r.sclFlag & ~clrA[4:2]) | sclSet; // RULE2
        st_nxt.otsFlag  = (st_r.otsFlag & ~clrA[1]) | st_r.s2.overtempShutdown; // RULE12
        st_nxt.uvwFlag  = (st_r.uvwFlag & ~clrA[8]) | st_r.s2.supplyLowWarning; // RULE7
        st_nxt.uvloFlag = st_r.uvloFlag & ~clrA[9]; // RULE9
        st_nxt.vguvFlag = (st_r.vguvFlag & ~clrS[3]) | st_r.s2.gateSupplyLow; // RULE10
        st_nxt.bsuvFlag = (st_r.bsuvFlag & ~clrS[2:0]) | st_r.s2.bootSupplyLow; // RULE11

        // Serial slave
        case (st_r.spi)
            PS_IDLE: begin
                st_nxt.bitCnt = '0;
                if (!st_r.s2.chipSelectN)
                    st_nxt.spi = PS_SHIFT;
            end
            PS_SHIFT, PS_OVER: begin
                if (st_r.s2.serialClk & ~st_r.sclkPrev) begin
                    st_nxt.inShift = {st_r.inShift[14:0], st_r.s2.serialIn}; // RULE15
                    st_nxt.bitCnt  = st_r.bitCnt + 5'h01;
                    st_nxt.spi = (st_r.bitCnt == `PDS_LAST_BIT) ? PS_OVER : PS_SHIFT;
                    if (st_r.bitCnt == `PDS_HDR_BITS)
                        st_nxt.rdWord = rdMux; // RULE26
                end
                if (~st_r.s2.serialClk & st_r.sclkPrev) begin
                    if (st_r.bitCnt > `PDS_HDR_BITS && st_r.bitCnt < `PDS_FRAME_BITS)
                        st_nxt.outBit = st_r.rdWord[4'(`PDS_LAST_BIT - st_r.bitCnt)]; // RULE26
                    else
                        st_nxt.outBit = st_r.inShift[0];
                end
                if (st_r.s2.chipSelectN)
                    st_nxt.spi = PS_IDLE;
            end
            default: st_nxt.spi = PS_IDLE;
        endcase

        // Lockout acts as a reset that leaves its own mark
        if (st_r.s2.supplyLockout) begin
            st_nxt = RST;
            st_nxt.s1 = pinsIn;
            st_nxt.s2 = st_r.s1;
            st_nxt.uvloFlag = 1'b1; // RULE8 RULE9
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            st_r <= RST;
        else
            st_r <= st_nxt;
    end

    // Outputs
    assign serialOut        = st_r.outBit;
    assign serialOutEn      = ~st_r.s2.chipSelectN; // RULE16
    assign alarmOutN        = 1'b0;
    assign alarmOutNEn      = alarmCause; // RULE2 RULE21
    assign bootRefreshStart = st_r.refresh;
    assign drive.enable     = effEn;
    assign drive.level      = effIn;
    assign drive.hsOn       = hsOn;
    assign drive.lsOn       = lsOn;
    assign drive.loadProbe  = st_r.outCtl[`PDS_F_OLS +: 3]; // RULE5
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            analog.deadTimeSel[c]       = st_r.chanCfg[c][`PDS_F_DT +: 3];
            analog.slewSel[c]           = st_r.chanCfg[c][`PDS_F_SR +: 2];
            analog.senseGainSel[c]      = st_r.chanCfg[c][`PDS_F_GN +: 3];
            analog.shortThresholdSel[c] = st_r.modeCfg[`PDS_F_SC + 3*c +: 3];
        end
        analog.senseChannelSel = st_r.modeCfg[`PDS_F_MUX +: 2];
        analog.reversePumpOn   = st_r.pumpOn; // RULE22
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_sdoQuiet;
        st_r.s2.chipSelectN |-> !serialOutEn;
    endproperty
    a_sdoQuiet: assert property (p_sdoQuiet) else $error("serial out driven while deselected"); // RULE16

    property p_shortAlarm;
        (|(st_r.schFlag & ~$past(st_r.schFlag))) |-> alarmOutNEn && alarmWord[0];
    endproperty
    a_shortAlarm: assert property (p_shortAlarm) else $error("short without alarm"); // RULE2

    property p_summaryOr;
        alarmWord[0] == (|alarmWord[9:1]) || (alarmWord[10] && alarmWord[0] == (|alarmWord[9:1]));
    endproperty
    a_summaryOr: assert property (p_summaryOr) else $error("summary is not OR of flags"); // RULE20

    property p_latched;
        st_r.modeCfg[`PDS_F_OVERCURRENT_RESTART_MODE] && st_r.schFlag[0] && st_r.chanOff[0] |=> !hsOn[0] && !lsOn[0];
    endproperty
    a_latched: assert property (p_latched) else $error("latched channel drove"); // RULE4

    property p_retryHold;
        st_r.chanOff[0] && !st_r.modeCfg[`PDS_F_OVERCURRENT_RESTART_MODE] && st_r.retryCnt[0] < 18'(RETRY_CYC - 1)
            && !st_r.s2.supplyLockout |=> st_r.chanOff[0];
    endproperty
    a_retryHold: assert property (p_retryHold) else $error("retry ended early"); // RULE3

    property p_warnSilent;
        !summary && !st_r.vguvFlag && st_r.bsuvFlag == 3'h0 |-> !alarmOutNEn;
    endproperty
    a_warnSilent: assert property (p_warnSilent) else $error("warning drove alarm"); // RULE13

    property p_xorEnable;
        drive.enable == (st_r.s2.channelEnablePin ^ {st_r.outCtl[4], st_r.outCtl[2], st_r.outCtl[0]});
    endproperty
    a_xorEnable: assert property (p_xorEnable) else $error("enable is not pin xor bit"); // RULE18

    property p_noDetect;
        !st_r.chanCfg[0][`PDS_F_SCEN] |=> !(st_r.schFlag[0] && !$past(st_r.schFlag[0]));
    endproperty
    a_noDetect: assert property (p_noDetect) else $error("short flagged while disabled"); // RULE19

    property p_cfgCommit;
        st_r.chanCfg[0] != $past(st_r.chanCfg[0]) |-> $past(commit) || $past(st_r.s2.supplyLockout);
    endproperty
    a_cfgCommit: assert property (p_cfgCommit) else $error("write without full frame"); // RULE25

    property p_lockMark;
        st_r.s2.supplyLockout ##1 !st_r.s2.supplyLockout |-> st_r.uvloFlag && alarmOutNEn;
    endproperty
    a_lockMark: assert property (p_lockMark) else $error("lockout not recorded"); // RULE9

    property p_thermalOff;
        st_r.otsFlag |-> drive.hsOn == 3'h0 && drive.lsOn == 3'h0;
    endproperty
    a_thermalOff: assert property (p_thermalOff) else $error("driving in thermal stop"); // RULE12

    c_write: cover property (commit);
    c_short: cover property (|st_r.schFlag ##1 !st_r.chanOff[0]);
    c_read:  cover property (st_r.spi == PS_OVER && !st_r.inShift[`PDS_F_DIR]);
    c_pump:  cover property (st_r.pumpOn);

endmodule : pds_regs

// ---- testbench/pds_spi_master.sv ----
// Serial master model for the register block's select, clock and data pins.
// Assumes clk is the block's clk_sys; serial clock is 12 clk a period.
`timescale 1ns/1ps
module pds_spi_master (
    // Clock
    input  wire logic clk,
    // Serial pins
    input  wire logic serialOut,
    input  wire logic serialOutEn,
    output logic      chipSelectN,
    output logic      serialClk,
    output logic      serialIn
);
    logic lastOut = 1'b0;
    logic sdoLine;

    // Idle pins at time zero, clock stands low outside frames
    initial begin
        chipSelectN = 1'b1;
        serialClk   = 1'b0;
        serialIn    = 1'b0;
    end

    // Released line floats, so show the inverse of the last driven bit
    assign sdoLine = serialOutEn ? serialOut : ~lastOut;
    always @(posedge clk) if (serialOutEn) lastOut <= serialOut;

    // One frame of nBits rising edges, MSB first
    task automatic xfer(input logic [15:0] w, input int nBits, output logic [11:0] rd);
        rd = 12'h000;
        @(posedge clk) chipSelectN <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < nBits; i++) begin
            serialIn <= w[15 - i];
            repeat (6) @(posedge clk);
            serialClk <= 1'b1;
            if (i >= 4) rd[15 - i] = sdoLine;
            repeat (6) @(posedge clk);
            serialClk <= 1'b0;
        end
        repeat (6) @(posedge clk);
        chipSelectN <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : xfer
endmodule : pds_spi_master

// ---- testbench/tb_top.sv ----
// Self-checking bench for the pre-driver register block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "pds_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
    import pds_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    pds_pins_s   pinsTb;
    pds_pins_s   pinsIn;
    logic        serialOut, serialOutEn, alarmOutN, alarmOutNEn, bootRefreshStart;
    logic        csN, sck, serial_in;
    pds_drive_s  drive;
    pds_analog_s analog;
    int          fail_count   = 0;
    int          total_checks = 0;
    int          refreshCnt   = 0;

    // Clock and pin assembly
    always #2 clk_sys = ~clk_sys;
    always_comb begin
        pinsIn = pinsTb;
        pinsIn.chipSelectN = csN;
        pinsIn.serialClk = sck;
        pinsIn.serialIn = serial_in;
    end
    always @(posedge clk_sys) if (bootRefreshStart === 1'b1) refreshCnt <= refreshCnt + 1;

    // Small counts keep the run short
    pds_regs #(.BLANK4_CYC(20), .BLANK5_CYC(30), .BLANK6_CYC(40), .BLANK7_CYC(50),
        .RETRY_CYC(60)) i_pds_regs (.clk_sys(clk_sys), .reset(reset), .pinsIn(pinsIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .alarmOutN(alarmOutN),
        .alarmOutNEn(alarmOutNEn), .drive(drive), .analog(analog),
        .bootRefreshStart(bootRefreshStart));
    pds_spi_master i_pds_spi_master (.clk(clk_sys), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .chipSelectN(csN), .serialClk(sck), .serialIn(serial_in));

    // Status word with its summary bit
    function automatic logic [11:0] fw(input logic [11:0] b);
        return {b[11:1], |b[9:1]};
    endfunction : fw

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic hold(input pds_pins_s m, input logic on);
        @(posedge clk_sys) pinsTb <= on ? (pinsTb | m) : (pinsTb & ~m);
        cyc(6);
    endtask : hold

    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        logic [11:0] x;
        i_pds_spi_master.xfer({a, 1'b1, d}, 16, x);
    endtask : wr

    task automatic rdChk(input logic [2:0] a, input logic [11:0] e);
        logic [11:0] x;
        i_pds_spi_master.xfer({a, 1'b0, 12'h000}, 16, x);
        `CHK(x, e)
    endtask : rdChk

    // Raise a fault, check it latches, ignores 0 and clears on 1
    task automatic latchChk(input pds_pins_s m, input logic [2:0] a, input logic [11:0] e);
        hold(m, 1'b1);
        hold(m, 1'b0);
        `CHK(alarmOutNEn, 1'b1)
        `CHK(alarmOutN, 1'b0)
        wr(a, 12'h000);
        rdChk(a, e);
        wr(a, e);
        rdChk(a, 12'h000);
        `CHK(alarmOutNEn, 1'b0)
    endtask : latchChk

    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Hang guard, far beyond the expected 80 us
    initial begin
        #400_000;
        fail_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        pds_pins_s   m;
        pds_pins_s   n;
        logic [11:0] d;
        logic [2:0]  a3;
        pinsTb = '0;
        void'($urandom(32'h8838_36dc));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        cyc(3);
        for (int a = 0; a < 8; a++) rdChk(3'(a), (a > 0 && a < 4) ? 12'h01c : 12'h000);
        `CHK(serialOutEn, 1'b0)
        repeat (12) begin
            a3 = 3'($urandom_range(4, 1));
            d = 12'($urandom);
            wr(a3, d);
            rdChk(a3, d);
            if (a3 == 3'h1)
                `CHK({analog.senseGainSel[0], analog.deadTimeSel[0], analog.slewSel[0]}, {d[10:8], d[4:2], d[1:0]})
            if (a3 == 3'h4)
                `CHK({analog.shortThresholdSel, analog.senseChannelSel}, {d[11:3], d[1:0]})
        end
        wr(3'h4, 12'h000);
        i_pds_spi_master.xfer(16'h9fff, 15, d);
        rdChk(3'h4, 12'h000);
        // Pin and soft bit mix, sense bits are not writable
        repeat (8) begin
            d = 12'($urandom);
            a3 = 3'($urandom);
            @(posedge clk_sys);
            pinsTb.channelEnablePin <= a3;
            pinsTb.channelInputPin <= ~a3;
            pinsTb.outputSense <= ~d[11:9];
            wr(3'h0, d);
            rdChk(3'h0, {~d[11:9], d[8:0]});
            `CHK(drive.enable, a3 ^ {d[4], d[2], d[0]})
            `CHK(drive.level, ~a3 ^ {d[5], d[3], d[1]})
            `CHK(drive.loadProbe, d[8:6])
        end
        @(posedge clk_sys) pinsTb <= '0;
        wr(3'h0, 12'h000);
        m = '0;
        m.supplyLowWarning = 1'b1;
        latchChk(m, 3'h5, fw(12'h100));
        m = '0;
        m.gateSupplyLow = 1'b1;
        latchChk(m, 3'h6, 12'h001);
        for (int k = 0; k < 3; k++) begin
            m = '0;
            m.bootSupplyLow = 3'(1 << k);
            latchChk(m, 3'h6, 12'h008 >> k);
        end
        `CHK(refreshCnt, 3)
        m = '0;
        m.overtempWarning = 1'b1;
        hold(m, 1'b1);
        rdChk(3'h5, 12'h400);
        `CHK(alarmOutNEn, 1'b0)
        hold(m, 1'b0);
        rdChk(3'h5, 12'h000);
        m = '0;
        m.overtempShutdown = 1'b1;
        hold(m, 1'b1);
        wr(3'h5, 12'h002);
        rdChk(3'h5, fw(12'h002));
        hold(m, 1'b0);
        wr(3'h5, 12'h002);
        rdChk(3'h5, 12'h000);
        // Pump toggles on 1, ignores 0
        for (int k = 0; k < 3; k++) begin
            wr(3'h5, (k == 1) ? 12'h000 : 12'h800);
            `CHK(analog.reversePumpOn, 1'(k < 2))
        end
        // High side short, detection off then on, latched mode
        wr(3'h1, 12'h080);
        wr(3'h4, 12'h004);
        n = '0;
        n.channelEnablePin = 3'b001;
        n.channelInputPin = 3'b001;
        m = '0;
        m.hsDsOver = 3'b001;
        hold(m, 1'b1);
        hold(n, 1'b1);
        cyc(40);
        `CHK(alarmOutNEn, 1'b0)
        hold(n, 1'b0);
        wr(3'h1, 12'h880);
        hold(n, 1'b1);
        cyc(4);
        `CHK(alarmOutNEn, 1'b0)
        cyc(30);
        `CHK(alarmOutNEn, 1'b1)
        rdChk(3'h5, fw(12'h020));
        hold(m, 1'b0);
        `CHK(drive.hsOn[0], 1'b0)
        wr(3'h5, 12'h020);
        cyc(4);
        `CHK(drive.hsOn[0], 1'b1)
        // Low side short, auto-restart mode
        wr(3'h4, 12'h000);
        m = '0;
        m.lsDsOver = 3'b001;
        n.channelEnablePin = 3'b000;
        hold(n, 1'b0);
        hold(m, 1'b1);
        cyc(28);
        `CHK(drive.lsOn[0], 1'b0)
        hold(m, 1'b0);
        cyc(50);
        `CHK(drive.lsOn[0], 1'b1)
        rdChk(3'h5, fw(12'h004));
        @(posedge clk_sys) pinsTb <= '0;
        // Supply lockout resets registers and leaves its flag
        wr(3'h1, 12'h123);
        m = '0;
        m.supplyLockout = 1'b1;
        hold(m, 1'b1);
        hold(m, 1'b0);
        rdChk(3'h1, 12'h01c);
        rdChk(3'h5, fw(12'h200));
        wr(3'h5, 12'h200);
        rdChk(3'h5, 12'h000);
        tally_and_finish();
    end
endmodule : tb_top
